// ==== mgmt_pkg.sv ====
// Shared constants for the module management block: bus address, memory map,
// reset values and timing counts.
// Assumes a 200 MHz system clock; all cycle counts below except PIPE_LATENCY derive from that rate.
package mgmt_pkg;

   // Serial bus device address, write form; bit 0 is the direction bit
   localparam logic [7:0] DEV_ADDR          = 8'ha0;

   // Memory organisation
   localparam int         PAGE_BYTES        = 128;
   localparam int         UPPER_PAGES_DEF   = 4;

   // Lower page offsets and field positions
   localparam logic [7:0] STATUS_OFS        = 8'h02;
   localparam int         NOT_READY_BIT     = 0;
   localparam logic [7:0] LOS_FLAG_OFS      = 8'h03;
   localparam logic [7:0] TX_FAULT_FLAG_OFS = 8'h04;
   localparam logic [7:0] READY_FLAG_OFS    = 8'h06;
   localparam logic [7:0] LOS_MASK_OFS      = 8'h64;
   localparam logic [7:0] TX_FAULT_MASK_OFS = 8'h65;
   localparam logic [7:0] PAGE_SEL_OFS      = 8'h7f;
   localparam int         LANES             = 4;

   // Reset values
   localparam logic [7:0] MEM_RESET         = 8'h00;
   localparam logic [3:0] FLAG_RESET        = 4'h0;
   // Pin order: low power, select_n, restart_n, sda, scl; idle bus reads high
   localparam logic [4:0] SYNC_RESET        = 5'h0f;

   // Timing, in the printed units
   localparam int CLK_MHZ                   = 200;
   localparam int INIT_TIME_MS              = 2000;
   localparam int RESTART_MIN_US            = 2;
   localparam int LOW_POWER_ENTRY_TIME_US   = 100;
   localparam int ATTENTION_ASSERT_TIME_MS  = 200;
   localparam int ATTENTION_RELEASE_TIME_US = 500;

   // Cycle counts derived from the times
   localparam int INIT_CYCLES               = INIT_TIME_MS * CLK_MHZ * 1000;
   localparam int RESTART_MIN_CYCLES        = RESTART_MIN_US * CLK_MHZ;
   localparam int LOW_POWER_ENTRY_CYCLES    = LOW_POWER_ENTRY_TIME_US * CLK_MHZ;
   localparam int ATTENTION_ASSERT_CYCLES   = ATTENTION_ASSERT_TIME_MS * CLK_MHZ * 1000;
   localparam int ATTENTION_RELEASE_CYCLES  = ATTENTION_RELEASE_TIME_US * CLK_MHZ;

   // Worst-case pin-to-pin latency of the synchronised paths, in cycles
   localparam int PIPE_LATENCY              = 4;

endpackage

// ==== mem_port_if.sv ====
// Port between the serial bus target and the management memory.
// Assumes both ends run on sys_clk; addr is valid whenever wrEn or readDone is high.
`timescale 1ns/1ps
interface mem_port_if;
   logic [7:0] addr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic       wrEn;
   logic       readDone;

   modport target (output addr, output wrData, output wrEn, output readDone,
                   input rdData);
   modport store  (input addr, input wrData, input wrEn, input readDone,
                   output rdData);
endinterface

// ==== serial_target.sv ====
// Two-wire serial bus target: address match, offset byte, writes and reads.
// Assumes sclIn and sdaIn are already synchronised to sys_clk; no clock stretching.
`timescale 1ns/1ps
module serial_target
   import mgmt_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   mem_port_if.target mem
);

   typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK} tstate_t;

   typedef struct packed {
      tstate_t    state;
      logic [7:0] shift;
      logic [2:0] bitCnt;
      logic       byteDone;
      logic       rw;
      logic       firstByte;
      logic       masterAck;
      logic [7:0] ptr;
      logic       sdaOe;
      logic       sclPrev;
      logic       sdaPrev;
      logic       wrEn;
      logic [7:0] wrData;
      logic       readDone;
   } tgt_t;

   tgt_t tgt_reg;
   tgt_t tgt_next;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;

   // Edge and bus condition detection on the synchronised pins
   assign sclRise   = sclIn & ~tgt_reg.sclPrev;
   assign sclFall   = ~sclIn & tgt_reg.sclPrev;
   assign startSeen = tgt_reg.sclPrev & sclIn & tgt_reg.sdaPrev & ~sdaIn;
   assign stopSeen  = tgt_reg.sclPrev & sclIn & ~tgt_reg.sdaPrev & sdaIn;

   // Bit engine; data changes only while SCL is low, so a start or stop always wins
   always_comb begin
      tgt_next          = tgt_reg;
      tgt_next.wrEn     = 1'b0;
      tgt_next.readDone = 1'b0;
      tgt_next.sclPrev  = sclIn;
      tgt_next.sdaPrev  = sdaIn;
      // Pointer advances after every byte written or fetched
      if (tgt_reg.wrEn || tgt_reg.readDone) begin
         tgt_next.ptr = tgt_reg.ptr + 8'h01;
      end
      if (!enable) begin
         tgt_next.state = IDLE;
         tgt_next.sdaOe = 1'b0;
      end else if (startSeen) begin
         tgt_next.state     = ADDR;
         tgt_next.bitCnt    = 3'h0;
         tgt_next.byteDone  = 1'b0;
         tgt_next.firstByte = 1'b1;
         tgt_next.sdaOe     = 1'b0;
      end else if (stopSeen) begin
         tgt_next.state = IDLE;
         tgt_next.sdaOe = 1'b0;
      end else begin
         case (tgt_reg.state)
            ADDR, RX: begin
               if (sclRise) begin
                  tgt_next.shift    = {tgt_reg.shift[6:0], sdaIn};
                  tgt_next.bitCnt   = tgt_reg.bitCnt + 3'h1;
                  tgt_next.byteDone = (tgt_reg.bitCnt == 3'h7);
               end else if (sclFall && tgt_reg.byteDone) begin
                  tgt_next.byteDone = 1'b0;
                  if (tgt_reg.state == ADDR) begin
                     // Only our own address is acknowledged
                     if (tgt_reg.shift[7:1] == DEV_ADDR[7:1]) begin
                        tgt_next.sdaOe = 1'b1;
                        tgt_next.rw    = tgt_reg.shift[0];
                        tgt_next.state = ADDR_ACK;
                     end else begin
                        tgt_next.state = IDLE;
                     end
                  end else begin
                     tgt_next.sdaOe = 1'b1;
                     tgt_next.state = RX_ACK;
                     if (tgt_reg.firstByte) begin
                        tgt_next.ptr       = tgt_reg.shift;
                        tgt_next.firstByte = 1'b0;
                     end else begin
                        tgt_next.wrEn   = 1'b1;
                        tgt_next.wrData = tgt_reg.shift;
                     end
                  end
               end
            end
            ADDR_ACK: begin
               if (sclFall) begin
                  tgt_next.bitCnt = 3'h0;
                  if (tgt_reg.rw) begin
                     // Fetch is also the clear point of a latched flag
                     tgt_next.shift    = mem.rdData;
                     tgt_next.sdaOe    = ~mem.rdData[7];
                     tgt_next.readDone = 1'b1;
                     tgt_next.state    = TX;
                  end else begin
                     tgt_next.sdaOe = 1'b0;
                     tgt_next.state = RX;
                  end
               end
            end
            RX_ACK: begin
               if (sclFall) begin
                  tgt_next.sdaOe  = 1'b0;
                  tgt_next.bitCnt = 3'h0;
                  tgt_next.state  = RX;
               end
            end
            TX: begin
               if (sclFall) begin
                  tgt_next.bitCnt = tgt_reg.bitCnt + 3'h1;
                  if (tgt_reg.bitCnt == 3'h7) begin
                     tgt_next.sdaOe = 1'b0;
                     tgt_next.state = TX_ACK;
                  end else begin
                     tgt_next.shift = {tgt_reg.shift[6:0], 1'b0};
                     tgt_next.sdaOe = ~tgt_reg.shift[6];
                  end
               end
            end
            TX_ACK: begin
               if (sclRise) begin
                  tgt_next.masterAck = ~sdaIn;
               end else if (sclFall) begin
                  if (tgt_reg.masterAck) begin
                     tgt_next.shift    = mem.rdData;
                     tgt_next.sdaOe    = ~mem.rdData[7];
                     tgt_next.readDone = 1'b1;
                     tgt_next.bitCnt   = 3'h0;
                     tgt_next.state    = TX;
                  end else begin
                     tgt_next.state = IDLE;
                  end
               end
            end
            default: begin
               tgt_next.sdaOe = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tgt_reg         <= '0;
         tgt_reg.state   <= IDLE;
         tgt_reg.sclPrev <= 1'b1;
         tgt_reg.sdaPrev <= 1'b1;
      end else begin
         tgt_reg <= tgt_next;
      end
   end

   assign sdaOut       = 1'b0;      // Open drain: only ever pulls low
   assign sdaOe        = tgt_reg.sdaOe;
   assign mem.addr     = tgt_reg.ptr;
   assign mem.wrEn     = tgt_reg.wrEn;
   assign mem.wrData   = tgt_reg.wrData;
   assign mem.readDone = tgt_reg.readDone;

endmodule

// ==== module_mgmt_status_interrupt.sv ====
// Management memory, flag latching, attention output and start-up timing
// of a four-lane pluggable module.
// Assumes rxLos and txFault come from logic on sys_clk; the pins are asynchronous.
//
// What this block does
// - Memory is one fixed 128-byte lower page plus several upper pages sharing offsets 128-255.
// - Slow content such as identity and thresholds lives in upper pages reached via page select.
// - The block answers on the serial bus only at device address A0h.
// - All interrupt flags sit in the lower page so one read sequence collects them.
// - Fully functional within 2000 ms of power on, hot plug or restart release.
// - A restart low level longer than 2 us is taken as a reset.
// - The serial bus answers within 2000 ms of power on.
// - Within 2000 ms of power on, bit 0 of byte 2 clears and the attention output goes active.
// - A high low-power request drops the module to its low power level within 100 us.
// - The attention output goes low within 200 ms of a triggering condition.
// - Reading a latched flag clears it and attention releases within 500 us of that read.
// - Entering receive signal loss sets its flag and asserts attention within 100 ms.
// - Fully functional means attention asserted because the not-ready bit has cleared.
// - A set mask bit stops its flag driving attention within 100 ms; clearing restores it.
// - The serial bus answers only while module select is low, within 100 us either way.
`timescale 1ns/1ps
module module_mgmt_status_interrupt
   import mgmt_pkg::*;
#(
   parameter int unsigned INIT_CYCLES_P = INIT_CYCLES,
   parameter int unsigned UPPER_PAGES   = UPPER_PAGES_DEF
)(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             sclIn,
   input  wire logic             sdaIn,
   output logic                  sdaOut,
   output logic                  sdaOe,
   input  wire logic             module_select_n,
   input  wire logic             module_restart_n,
   input  wire logic             low_power_request,
   input  wire logic [LANES-1:0] rxLos,
   input  wire logic [LANES-1:0] txFault,
   output logic                  attention_out_n,
   output logic                  lowPowerActive,
   output logic                  moduleReady
);

   localparam int UPPER_BYTES = UPPER_PAGES * PAGE_BYTES;
   localparam int UIDX_W      = $clog2(UPPER_BYTES);

   // Refuse settings the counters and page decode cannot serve
   if (UPPER_PAGES < 1 || UPPER_PAGES > 255) begin : g_bad_pages
      $error("UPPER_PAGES must lie in 1..255");
   end
   if (INIT_CYCLES_P < 1) begin : g_bad_init
      $error("INIT_CYCLES_P must be at least 1");
   end
   if (RESTART_MIN_CYCLES >= 65535) begin : g_bad_restart
      $error("Restart pulse count exceeds its 16-bit counter");
   end
   if (PIPE_LATENCY > LOW_POWER_ENTRY_CYCLES || PIPE_LATENCY > ATTENTION_RELEASE_CYCLES
       || PIPE_LATENCY > ATTENTION_ASSERT_CYCLES) begin : g_bad_latency
      $error("Pin latency exceeds a response limit");
   end

   typedef struct packed {
      logic [4:0]                   sync1;
      logic [4:0]                   sync2;
      logic [15:0]                  lowCnt;
      logic                         restartHeld;
      logic [31:0]                  initCnt;
      logic                         notReady;
      logic                         readyFlag;
      logic [LANES-1:0]             losFlag;
      logic [LANES-1:0]             txFlag;
      logic                         attention;
      logic                         lowPower;
      logic [PAGE_BYTES-1:0][7:0]   lowMem;
      logic [UPPER_BYTES-1:0][7:0]  upperMem;
   } mgmt_t;

   mgmt_t            mgmt_reg;
   mgmt_t            mgmt_next;
   mem_port_if       memPort ();
   logic             sclSync;
   logic             sdaSync;
   logic             restartPin;
   logic             selectedN;
   logic [7:0]       pageSel;
   logic             pageValid;
   logic [UIDX_W-1:0] upperIdx;
   logic [LANES-1:0] losClr;
   logic [LANES-1:0] txClr;
   logic             readyClr;
   logic             busEnable;
   logic [7:0]       rdData;

   // Second synchroniser stage is the only one that logic may read
   assign sclSync    = mgmt_reg.sync2[0];
   assign sdaSync    = mgmt_reg.sync2[1];
   assign restartPin = mgmt_reg.sync2[2];
   assign selectedN  = mgmt_reg.sync2[3];

   // Upper page decode; an unimplemented page reads zero and ignores writes
   assign pageSel   = mgmt_reg.lowMem[PAGE_SEL_OFS[6:0]];
   assign pageValid = (32'(pageSel) < UPPER_PAGES);
   assign upperIdx  = UIDX_W'((32'(pageSel) * PAGE_BYTES) + 32'(memPort.addr[6:0]));

   // Bus is live only while selected and not held in restart
   assign busEnable = ~selectedN & ~mgmt_reg.restartHeld;

   // Clear-on-read strobes, one per latched flag byte
   assign losClr   = (memPort.readDone && memPort.addr == LOS_FLAG_OFS)
                     ? mgmt_reg.losFlag : FLAG_RESET;
   assign txClr    = (memPort.readDone && memPort.addr == TX_FAULT_FLAG_OFS)
                     ? mgmt_reg.txFlag : FLAG_RESET;
   assign readyClr = memPort.readDone && memPort.addr == READY_FLAG_OFS;

   // Read mux: live status and flag bytes override the plain storage
   always_comb begin
      rdData = MEM_RESET;
      if (memPort.addr[7]) begin
         if (pageValid) begin
            rdData = mgmt_reg.upperMem[upperIdx];
         end
      end else begin
         case (memPort.addr)
            STATUS_OFS: begin
               rdData[NOT_READY_BIT] = mgmt_reg.notReady;
            end
            LOS_FLAG_OFS: begin
               rdData[LANES-1:0] = mgmt_reg.losFlag;
            end
            TX_FAULT_FLAG_OFS: begin
               rdData[LANES-1:0] = mgmt_reg.txFlag;
            end
            READY_FLAG_OFS: begin
               rdData[0] = mgmt_reg.readyFlag;
            end
            default: begin
               rdData = mgmt_reg.lowMem[memPort.addr[6:0]];
            end
         endcase
      end
   end

   assign memPort.rdData = rdData;

   // Next-state logic for synchronisers, restart, start-up, flags and memory
   always_comb begin
      mgmt_next       = mgmt_reg;
      mgmt_next.sync1 = {low_power_request, module_select_n, module_restart_n, sdaIn, sclIn};
      mgmt_next.sync2 = mgmt_reg.sync1;

      // Restart pin: only a low level outlasting the minimum pulse counts
      if (!restartPin) begin
         if (mgmt_reg.lowCnt != 16'hffff) begin
            mgmt_next.lowCnt = mgmt_reg.lowCnt + 16'h0001;
         end
         if (32'(mgmt_reg.lowCnt) >= RESTART_MIN_CYCLES) begin
            mgmt_next.restartHeld = 1'b1;
         end
      end else begin
         mgmt_next.lowCnt = 16'h0000;
         if (mgmt_reg.restartHeld) begin
            // Rising edge of a qualified restart starts a fresh initialisation
            mgmt_next.restartHeld = 1'b0;
            mgmt_next.initCnt     = 32'h0000_0000;
            mgmt_next.notReady    = 1'b1;
            mgmt_next.readyFlag   = 1'b0;
            mgmt_next.losFlag     = FLAG_RESET;
            mgmt_next.txFlag      = FLAG_RESET;
            mgmt_next.lowMem      = '0;
         end
      end

      // Start-up timer; the ready flag is what raises attention at the end
      if (mgmt_reg.notReady && !mgmt_reg.restartHeld) begin
         if (mgmt_reg.initCnt >= INIT_CYCLES_P - 1) begin
            mgmt_next.notReady  = 1'b0;
            mgmt_next.readyFlag = 1'b1;
         end else begin
            mgmt_next.initCnt = mgmt_reg.initCnt + 32'h0000_0001;
         end
      end else if (readyClr) begin
         mgmt_next.readyFlag = 1'b0;
      end

      // Flags latch while the condition is present; a new event beats a clear
      if (!mgmt_reg.restartHeld) begin
         mgmt_next.losFlag = (mgmt_reg.losFlag & ~losClr) | rxLos;
         mgmt_next.txFlag  = (mgmt_reg.txFlag & ~txClr) | txFault;
      end

      // Attention: any unmasked latched flag, or the start-up completion flag
      mgmt_next.attention = |(mgmt_reg.losFlag & ~mgmt_reg.lowMem[LOS_MASK_OFS[6:0]][LANES-1:0])
                          | |(mgmt_reg.txFlag & ~mgmt_reg.lowMem[TX_FAULT_MASK_OFS[6:0]][LANES-1:0])
                          | mgmt_reg.readyFlag;

      // Low power follows the synchronised request a few cycles later
      mgmt_next.lowPower = mgmt_reg.sync2[4];

      // Host writes; live status and flag bytes are read-only
      if (memPort.wrEn) begin
         if (memPort.addr[7]) begin
            if (pageValid) begin
               mgmt_next.upperMem[upperIdx] = memPort.wrData;
            end
         end else if (memPort.addr != STATUS_OFS && memPort.addr != LOS_FLAG_OFS
                      && memPort.addr != TX_FAULT_FLAG_OFS
                      && memPort.addr != READY_FLAG_OFS) begin
            mgmt_next.lowMem[memPort.addr[6:0]] = memPort.wrData;
         end
      end
   end

   // State register; power-on reset starts the module not ready
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mgmt_reg          <= '0;
         mgmt_reg.sync1    <= SYNC_RESET;
         mgmt_reg.sync2    <= SYNC_RESET;
         mgmt_reg.notReady <= 1'b1;
         mgmt_reg.losFlag  <= FLAG_RESET;
         mgmt_reg.txFlag   <= FLAG_RESET;
      end else begin
         mgmt_reg <= mgmt_next;
      end
   end

   // Serial bus target; it only sees synchronised pins
   serial_target u_target (
      .sys_clk (sys_clk),
      .rst     (rst),
      .enable  (busEnable),
      .sclIn   (sclSync),
      .sdaIn   (sdaSync),
      .sdaOut  (sdaOut),
      .sdaOe   (sdaOe),
      .mem     (memPort.target)
   );

   // Outputs straight from flip-flops
   assign attention_out_n = ~mgmt_reg.attention;
   assign lowPowerActive  = mgmt_reg.lowPower;
   assign moduleReady     = ~mgmt_reg.notReady;

endmodule

// ==== mgmt_props.sv ====
// Checker on the top ports of the management block.
// Assumes signal-loss masks stay clear and lane pulses last several cycles.
`timescale 1ns/1ps
module mgmt_props
   import mgmt_pkg::*;
#(
   parameter int unsigned INIT_CYCLES_P = 50
)(
   input wire logic             sys_clk,
   input wire logic             rst,
   input wire logic             sclIn,
   input wire logic             sdaIn,
   input wire logic             sdaOut,
   input wire logic             sdaOe,
   input wire logic             module_select_n,
   input wire logic             module_restart_n,
   input wire logic             low_power_request,
   input wire logic [LANES-1:0] rxLos,
   input wire logic [LANES-1:0] txFault,
   input wire logic             attention_out_n,
   input wire logic             lowPowerActive,
   input wire logic             moduleReady
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Slack covers a long restart pulse that may count as not ready
   localparam int unsigned LIMIT = INIT_CYCLES_P + 600;
   int unsigned waitCnt_reg;
   // Cycles spent not ready, cleared whenever ready is seen
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) waitCnt_reg <= 0;
      else waitCnt_reg <= moduleReady ? 0 : waitCnt_reg + 1;
   end
   sequence readyRise; $rose(moduleReady); endsequence
   sequence lossRise; $rose(|rxLos); endsequence
   a_ready_att: assert property (readyRise |-> ##[1:3] !attention_out_n)
      else $error("attention not raised by ready");
   a_ready_early: assert property (readyRise |-> waitCnt_reg >= INIT_CYCLES_P - 2)
      else $error("ready came too early");
   a_init_bound: assert property (!moduleReady |-> waitCnt_reg < LIMIT)
      else $error("ready never came");
   a_loss_att: assert property (lossRise |-> ##[1:3] !attention_out_n)
      else $error("attention late after signal loss");
   a_flag_hold: assert property ($fell(|rxLos) && !attention_out_n |=> !attention_out_n [*4])
      else $error("flag did not stay latched");
   a_lp_follow: assert property ($changed(low_power_request)
      |-> ##[2:4] lowPowerActive == low_power_request)
      else $error("low power did not follow request");
   a_lp_steady: assert property (low_power_request [*5] |-> lowPowerActive)
      else $error("low power dropped while requested");
   a_sel_quiet: assert property (module_select_n [*8] |-> !sdaOe)
      else $error("data line pulled while unselected");
endmodule

// ==== host_bus.sv ====
// Host model of the two-wire bus: 125 ns bus clock, open-drain data.
// Assumes the bench resolves the wire with a pull-up and feeds it back on sda.
`timescale 1ns/1ps
module host_bus (
   input  wire logic sda,
   output logic      scl,
   output logic      hostOe
);
   localparam real Q = 31.25;
   // Clock and data rest high between frames
   initial {scl, hostOe} = 2'b10;
   // One bus clock; data moves only while the clock is low
   task automatic clkBit(input logic low, output logic seen);
      hostOe = low;
      #Q scl = 1'b1;
      #Q seen = sda;
      #Q scl = 1'b0;
      #Q;
   endtask
   // Start when s is high, stop when low: data moves while the clock is high
   task automatic cond(input logic s);
      hostOe = ~s;
      #Q scl = 1'b1;
      #Q hostOe = s;
      #Q scl = ~s;
      #Q;
   endtask
   // Eight bits, most significant first, then the acknowledge clock
   task automatic xfer(input logic [7:0] tx, input logic ackOut,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         clkBit(~tx[i], rx[i]);
      end
      clkBit(ackOut, ack);
      ack = ~ack;
   endtask
   // Write one byte, or set the offset and read one byte ended by a NACK
   task automatic txn(input logic [7:0] dev, ofs, dat, input logic rd,
                      output logic [7:0] got, output logic ok);
      logic [7:0] d;
      logic       a1, a2, a3;
      cond(1'b1);
      xfer(dev, 1'b0, d, a1); // Device address
      xfer(ofs, 1'b0, d, a2);
      if (rd) begin
         cond(1'b1);
         xfer(dev | 8'h01, 1'b0, d, a3);
         xfer(8'hff, 1'b0, got, d[0]);
      end else begin
         xfer(dat, 1'b0, got, a3);
      end
      cond(1'b0);
      ok = a1 & a2 & a3;
   endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the management block with a host bus model.
// Assumes mgmt_props.sv and host_bus.sv are compiled before it.
`timescale 1ns/1ps
module tb;
   import mgmt_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       selN = 1'b0;
   logic       restartN = 1'b1;
   logic       lpReq = 1'b0;
   logic [3:0] rxLos = 4'h0;
   logic [3:0] txFault = 4'h0;
   logic       sdaOe, sdaOut, att, lpAct, ready, scl, hostOe, ok;
   logic [7:0] got;
   logic [7:0] pg [5];
   logic [1:0] lane;
   int         errCount = 0;
   int         comparisons = 0;
   int         cycles = 0;
   wire        sda = ~(sdaOe | hostOe); // Pull-up wins unless a party pulls low
   module_mgmt_status_interrupt #(.INIT_CYCLES_P(50)) i_module_mgmt_status_interrupt (
      .sys_clk(sys_clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .module_select_n(selN), .module_restart_n(restartN),
      .low_power_request(lpReq), .rxLos(rxLos), .txFault(txFault),
      .attention_out_n(att), .lowPowerActive(lpAct), .moduleReady(ready));
   host_bus i_host_bus (.sda(sda), .scl(scl), .hostOe(hostOe));
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic finalReport();
      if (errCount == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Guard against a hung bus or a start-up that never ends
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errCount++;
         finalReport();
      end
   end
   task automatic chk(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Outputs are looked at 1 ns after the edge so register updates have landed
   task automatic attChk(input logic exp, input int n);
      tick(n);
      #1 chk({7'h0, att}, {7'h0, exp});
   endtask
   task automatic rdChk(input logic [7:0] ofs, exp);
      i_host_bus.txn(DEV_ADDR, ofs, 8'h00, 1'b1, got, ok);
      chk({7'h0, ok}, 8'h01);
      chk(got, exp);
      chk({7'h0, sdaOut}, 8'h00);
   endtask
   task automatic wrChk(input logic [7:0] ofs, dat);
      i_host_bus.txn(DEV_ADDR, ofs, dat, 1'b1 ^ 1'b1, got, ok);
      chk({7'h0, ok}, 8'h01);
   endtask
   task automatic pulse(input logic [3:0] l, f);
      tick(1);
      rxLos <= l;
      txFault <= f;
      tick(6);
      rxLos <= 4'h0;
      txFault <= 4'h0;
   endtask
   task automatic waitReady();
      for (int i = 0; i < 700 && ready !== 1'b1; i++) tick(1);
      #1 chk({7'h0, ready}, 8'h01);
   endtask
   initial begin
      void'($urandom(32'h9f6a62cb));
      tick(16);
      rst <= 1'b0;
      attChk(1'b1, 8);
      waitReady();
      attChk(1'b0, 3);
      rdChk(STATUS_OFS, 8'h00);
      rdChk(READY_FLAG_OFS, 8'h01);
      attChk(1'b1, 2);
      // Random lanes latch, read back and clear on read; power request takes a random level
      repeat (3) begin
         lane = 2'($urandom);
         tick(1);
         lpReq <= 1'($urandom);
         pulse(4'h1 << lane, 4'h0);
         attChk(1'b0, 2);
         chk({7'h0, lpAct}, {7'h0, lpReq});
         rdChk(LOS_FLAG_OFS, 8'h01 << lane);
         pulse(4'h0, 4'h1 << lane);
         attChk(1'b0, 2);
         rdChk(TX_FAULT_FLAG_OFS, 8'h01 << lane);
         attChk(1'b1, 2);
      end
      wrChk(TX_FAULT_MASK_OFS, 8'h0f);
      pulse(4'h0, 4'h1 << lane);
      attChk(1'b1, 4);
      i_host_bus.txn(DEV_ADDR, TX_FAULT_FLAG_OFS, 8'h00, 1'b1, got, ok);
      chk(got, 8'h01 << lane);
      wrChk(TX_FAULT_MASK_OFS, 8'h00);
      pulse(4'h0, 4'h1 << lane);
      attChk(1'b0, 2);
      rdChk(TX_FAULT_FLAG_OFS, 8'h01 << lane);
      // Each upper page keeps its own byte; a page beyond the last reads zero
      for (int p = 0; p < 5; p++) begin
         pg[p] = (p < UPPER_PAGES_DEF) ? 8'($urandom) : 8'h00;
         wrChk(PAGE_SEL_OFS, 8'(p));
         wrChk(8'h90, pg[p]);
      end
      wrChk(8'h10, 8'ha5);
      for (int p = 0; p < 5; p++) begin
         wrChk(PAGE_SEL_OFS, 8'(p));
         rdChk(8'h90, pg[p]);
      end
      i_host_bus.txn(8'ha2, 8'h10, 8'h00, 1'b0, got, ok);
      chk({7'h0, ok}, 8'h00);
      tick(1);
      selN <= 1'b1;
      tick(10);
      i_host_bus.txn(DEV_ADDR, 8'h10, 8'h00, 1'b0, got, ok);
      chk({7'h0, ok}, 8'h00);
      tick(1);
      selN <= 1'b0;
      tick(10);
      rdChk(8'h10, 8'ha5);
      // A short restart low is ignored; a long one re-runs start-up, upper pages kept
      tick(1);
      restartN <= 1'b0;
      tick(100);
      restartN <= 1'b1;
      tick(8);
      rdChk(8'h10, 8'ha5);
      tick(1);
      restartN <= 1'b0;
      tick(450);                                  // Held 2.25 us, just past 2 us
      restartN <= 1'b1;
      tick(8);
      #1 chk({7'h0, ready}, 8'h00);
      waitReady();
      rdChk(8'h10, 8'h00);
      rdChk(8'h90, pg[0]);
      finalReport();
   end
endmodule
bind module_mgmt_status_interrupt mgmt_props #(.INIT_CYCLES_P(INIT_CYCLES_P)) i_mgmt_props (
   .sys_clk(sys_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .module_select_n(module_select_n), .module_restart_n(module_restart_n),
   .low_power_request(low_power_request), .rxLos(rxLos), .txFault(txFault),
   .attention_out_n(attention_out_n), .lowPowerActive(lowPowerActive),
   .moduleReady(moduleReady));
